// ---- hw/suck_top.sv ----
// Purpose: strap-selected clock mode control, usb bit-rate enable and
//          uart baud enable generation for a communications controller
// Assumes: sys_osc_in and ext_uart_clock_pin (usb_osc_in unused) are slow
//          reference levels sampled on mclk; analog plls stay outside
// Notes:   every derived clock is an enable on mclk, high one cycle per tick, except the sys_osc_out level and usb_osc_out, held low
`timescale 1ns/1ns

// Functional notes
// RULE_01: system pll mode follows the two system strap pins during reset.
// RULE_02: pll mode runs system clock at one, two or four times reference.
// RULE_03: usb path gives 48 mhz and divides it to 12 mhz.
// RULE_04: only full-speed usb timing; no low-speed rate exists.
// RULE_05: usb pll mode follows the two usb strap pins during reset.
// RULE_06: usb pll multiplies its reference by two or four.
// RULE_07: usb from system clock needs 48 mhz system, usb input low.
// RULE_08: own usb pll requires system clock of at least 24 mhz.
// RULE_09: software disables usb before dropping system below 24 mhz.
// RULE_10: shared source: 12 mhz uses 2x/4x, 24 mhz uses 1x/2x.
// RULE_11: bypass mode passes the reference straight to the system clock.
// RULE_12: fully static logic keeps state while the input clock stops.
// RULE_13: software slows hdlc and uart clocks before slowing system.
// RULE_14: each uart picks system clock or external pin, independently.
// RULE_15: baud tick is source divided by divisor; divisor is f/(16*baud).
// RULE_16: strap modes latch at reset release and hold until next reset.
module suck_top #(
  parameter int NUM_UART = 2
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // strap pins
  input  wire suck_pkg::suck_straps_t      straps,
  // reference inputs
  input  wire logic                        sys_osc_in,
  input  wire logic                        usb_osc_in,
  input  wire logic                        usb_pll_clk48_en,
  input  wire logic                        ext_uart_clock_pin,
  // register port
  input  wire suck_pkg::suck_bus_req_t     bus,
  output logic [15:0]                      rdata,
  // clock enables and oscillator outputs
  output logic                             system_clock_output,
  output logic                             sys_osc_out,
  output logic                             usb_osc_out,
  output logic                             usb_clk48_en,
  output logic                             usb_bit_en,
  output logic [NUM_UART-1:0]              baud_en,
  output logic [NUM_UART-1:0]              baud16_en,
  // latched modes
  output suck_pkg::suck_sys_mode_t         sys_mode,
  output suck_pkg::suck_usb_mode_t         usb_mode
);
  import suck_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]             sync_osc_a;
    logic [1:0]             sync_osc_b;
    logic [1:0]             sync_ucl_a;
    logic [1:0]             sync_ucl_b;
    logic [3:0]             sync_str_a;
    logic [3:0]             sync_str_b;
    suck_straps_t           strap_hold;
    logic                   in_rst;
    suck_sys_mode_t         sys_mode;
    suck_usb_mode_t         usb_mode;
    logic [SUCK_PH_W-1:0]   pll_cnt;
    logic [SUCK_PH_W-1:0]   usb_cnt;
    logic                   sys_en;
    logic                   clk48;
    logic                   bit_en;
    logic                   osc_prev;
    logic                   ucl_prev;
    logic [NUM_UART-1:0]    src_sel;
    logic [NUM_UART-1:0][SUCK_DIV_W-1:0] divisor;
    logic [NUM_UART-1:0][SUCK_DIV_W-1:0] div_cnt;
    logic [NUM_UART-1:0][3:0]            ovs_cnt;
    logic [NUM_UART-1:0]    b16;
    logic [NUM_UART-1:0]    b1;
    logic [15:0]            rdata;
  } suck_state_t;

  suck_state_t st_reg;
  suck_state_t st_next;

  logic                 osc_rise;
  logic                 ucl_rise;
  logic [SUCK_PH_W-1:0] ph_len;
  logic                 usb_src_tick;
  logic                 sel_ctrl;
  logic                 sel_stat;
  logic [NUM_UART-1:0]  sel_div;
  logic [NUM_UART-1:0]  uart_src;
  logic [15:0]          status_word;

  // --------------------------------------------------------------------
  // reference edges
  // --------------------------------------------------------------------
  always_comb begin
    osc_rise = st_reg.sync_osc_b[1] & ~st_reg.osc_prev;
    ucl_rise = st_reg.sync_ucl_b[1] & ~st_reg.ucl_prev;
  end

  // --------------------------------------------------------------------
  // ticks per reference edge
  // --------------------------------------------------------------------
  always_comb begin
    case (st_reg.sys_mode)
      SUCK_SYS_X1: begin
        ph_len = SUCK_X1_PH;                                // RULE_02
      end
      SUCK_SYS_X2: begin
        ph_len = SUCK_X2_PH;                                // RULE_02
      end
      SUCK_SYS_X4: begin
        ph_len = SUCK_X4_PH;                                // RULE_02
      end
      default: begin
        ph_len = SUCK_X1_PH;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // usb tick source
  // --------------------------------------------------------------------
  always_comb begin
    case (st_reg.usb_mode)
      SUCK_USB_FROM_SYS: begin
        usb_src_tick = st_reg.sys_en;                       // RULE_07
      end
      SUCK_USB_X2,
      SUCK_USB_X4: begin
        usb_src_tick = usb_pll_clk48_en;                    // RULE_06 RULE_10
      end
      default: begin
        usb_src_tick = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // uart source select
  // --------------------------------------------------------------------
  always_comb begin
    uart_src = '0;
    for (int i = 0; i < NUM_UART; i++) begin
      if (st_reg.src_sel[i]) begin
        uart_src[i] = ucl_rise;                             // RULE_14
      end else begin
        uart_src[i] = st_reg.sys_en;                        // RULE_14
      end
    end
  end

  // --------------------------------------------------------------------
  // address decode and status word
  // --------------------------------------------------------------------
  always_comb begin
    sel_ctrl    = 1'b0;
    sel_stat    = 1'b0;
    sel_div     = '0;
    status_word = {12'h000, st_reg.usb_mode, st_reg.sys_mode};
    if (bus.addr == SUCK_REG_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (bus.addr == SUCK_REG_STATUS) begin
      sel_stat = 1'b1;
    end else begin
      for (int i = 0; i < NUM_UART; i++) begin
        if (bus.addr == SUCK_REG_DIV + 16'(i * 16)) begin
          sel_div[i] = 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // ----------------------------------------------------------------
    // four-flop synchronisers on the references, two on the straps, then one edge stage
    // ----------------------------------------------------------------
    st_next.sync_osc_a = {st_reg.sync_osc_a[0], sys_osc_in};
    st_next.sync_osc_b = {st_reg.sync_osc_b[0], st_reg.sync_osc_a[1]};
    st_next.sync_ucl_a = {st_reg.sync_ucl_a[0], ext_uart_clock_pin};
    st_next.sync_ucl_b = {st_reg.sync_ucl_b[0], st_reg.sync_ucl_a[1]};
    st_next.sync_str_a = straps;
    st_next.sync_str_b = st_reg.sync_str_a;
    st_next.osc_prev   = st_reg.sync_osc_b[1];
    st_next.ucl_prev   = st_reg.sync_ucl_b[1];
    st_next.in_rst     = sys_rst;
    st_next.rdata      = 16'h0000;
    // ----------------------------------------------------------------
    // straps tracked while reset is held, frozen at release
    // ----------------------------------------------------------------
    if (sys_rst) begin
      st_next.strap_hold = st_reg.sync_str_b;             // RULE_01 RULE_05
    end
    if (st_reg.in_rst) begin
      st_next.sys_mode = suck_sys_mode_t'({st_reg.strap_hold.sys_b,
                                           st_reg.strap_hold.sys_a}); // RULE_16
      st_next.usb_mode = suck_usb_mode_t'({st_reg.strap_hold.usb_b,
                                           st_reg.strap_hold.usb_a}); // RULE_16
    end
    // ----------------------------------------------------------------
    // system clock enable, burst of ticks per reference edge
    // ----------------------------------------------------------------
    st_next.sys_en = 1'b0;
    if (st_reg.sys_mode == SUCK_SYS_BYPASS) begin
      st_next.sys_en  = osc_rise;                           // RULE_11 RULE_12
      st_next.pll_cnt = '0;
    end else if (osc_rise) begin
      st_next.sys_en  = 1'b1;                               // RULE_02
      st_next.pll_cnt = ph_len - 3'h1;
    end else if (st_reg.pll_cnt != '0) begin
      st_next.sys_en  = 1'b1;                               // RULE_02
      st_next.pll_cnt = st_reg.pll_cnt - 3'h1;
    end
    // ----------------------------------------------------------------
    // usb 48 -> 12 divider, full speed only
    // ----------------------------------------------------------------
    st_next.clk48  = usb_src_tick;                          // RULE_03
    st_next.bit_en = 1'b0;
    if (usb_src_tick) begin
      if (st_reg.usb_cnt == SUCK_USB_DIV_M1) begin
        st_next.usb_cnt = '0;
        st_next.bit_en  = 1'b1;                             // RULE_03 RULE_04
      end else begin
        st_next.usb_cnt = st_reg.usb_cnt + 3'h1;
      end
    end
    // ----------------------------------------------------------------
    // uart baud dividers, divisor zero acts as one
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_UART; i++) begin
      st_next.b16[i] = 1'b0;
      st_next.b1[i]  = 1'b0;
      if (uart_src[i]) begin
        if (st_reg.div_cnt[i] <= SUCK_DIV_ONE) begin
          st_next.div_cnt[i] = st_reg.divisor[i];
          st_next.b16[i]     = 1'b1;                        // RULE_15
          if (st_reg.ovs_cnt[i] == SUCK_OVERSAMPLE) begin
            st_next.ovs_cnt[i] = 4'h0;
            st_next.b1[i]      = 1'b1;                      // RULE_15
          end else begin
            st_next.ovs_cnt[i] = st_reg.ovs_cnt[i] + 4'h1;
          end
        end else begin
          st_next.div_cnt[i] = st_reg.div_cnt[i] - 16'h0001;
        end
      end
    end
    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (bus.wr && sel_ctrl) begin
      st_next.src_sel = bus.wdata[NUM_UART-1:0];            // RULE_14
    end
    for (int i = 0; i < NUM_UART; i++) begin
      if (bus.wr && sel_div[i]) begin
        st_next.divisor[i] = bus.wdata;                     // RULE_15
      end
    end
    // ----------------------------------------------------------------
    // register reads, unmapped offsets read zero
    // ----------------------------------------------------------------
    if (bus.rd && sel_ctrl) begin
      st_next.rdata = 16'(st_reg.src_sel);
    end else if (bus.rd && sel_stat) begin
      st_next.rdata = status_word;
    end
    for (int i = 0; i < NUM_UART; i++) begin
      if (bus.rd && sel_div[i]) begin
        st_next.rdata = st_reg.divisor[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // straps keep flowing through their synchronisers during reset
      st_reg.sync_osc_a <= '0;
      st_reg.sync_osc_b <= '0;
      st_reg.sync_ucl_a <= '0;
      st_reg.sync_ucl_b <= '0;
      st_reg.sync_str_a <= st_next.sync_str_a;
      st_reg.sync_str_b <= st_next.sync_str_b;
      st_reg.strap_hold <= st_next.strap_hold;
      st_reg.in_rst     <= 1'b1;
      st_reg.sys_mode   <= SUCK_SYS_BYPASS;
      st_reg.usb_mode   <= SUCK_USB_FROM_SYS;
      st_reg.pll_cnt    <= '0;
      st_reg.usb_cnt    <= '0;
      st_reg.sys_en     <= 1'b0;
      st_reg.clk48      <= 1'b0;
      st_reg.bit_en     <= 1'b0;
      st_reg.osc_prev   <= 1'b0;
      st_reg.ucl_prev   <= 1'b0;
      st_reg.src_sel    <= '0;
      st_reg.divisor    <= {NUM_UART{SUCK_DIV_RST}};
      st_reg.div_cnt    <= '0;
      st_reg.ovs_cnt    <= '0;
      st_reg.b16        <= '0;
      st_reg.b1         <= '0;
      st_reg.rdata      <= 16'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  always_comb begin
    rdata               = st_reg.rdata;
    system_clock_output = st_reg.sys_en;
    sys_osc_out         = ~st_reg.sync_osc_b[1];
    usb_osc_out         = 1'b0;
    usb_clk48_en        = st_reg.clk48;
    usb_bit_en          = st_reg.bit_en;
    baud16_en           = st_reg.b16;
    baud_en             = st_reg.b1;
    sys_mode            = st_reg.sys_mode;
    usb_mode            = st_reg.usb_mode;
  end

endmodule : suck_top

// ---- hw/suck_pkg.sv ----
// Purpose: shared constants and types for the clock generation block
// Assumes: one 50 MHz clock mclk, synchronous active-high reset
// Notes:   strap encodings and widths live here
package suck_pkg;

  // --------------------------------------------------------------------
  // strap encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SUCK_SYS_BYPASS = 2'b00,
    SUCK_SYS_X1     = 2'b01,
    SUCK_SYS_X2     = 2'b10,
    SUCK_SYS_X4     = 2'b11
  } suck_sys_mode_t;

  typedef enum logic [1:0] {
    SUCK_USB_FROM_SYS = 2'b00,
    SUCK_USB_X2       = 2'b01,
    SUCK_USB_X4       = 2'b10,
    SUCK_USB_OFF      = 2'b11
  } suck_usb_mode_t;

  // --------------------------------------------------------------------
  // widths and counts
  // --------------------------------------------------------------------
  localparam int          SUCK_DIV_W       = 16;
  localparam int          SUCK_PH_W        = 3;
  localparam logic [2:0]  SUCK_USB_DIV_M1  = 3'h3;  // 48 mhz / 4 = 12 mhz
  // system ticks issued per reference rising edge
  localparam logic [2:0]  SUCK_X1_PH       = 3'h1;
  localparam logic [2:0]  SUCK_X2_PH       = 3'h2;
  localparam logic [2:0]  SUCK_X4_PH       = 3'h4;
  localparam logic [15:0] SUCK_DIV_RST     = 16'h0001;
  localparam logic [15:0] SUCK_DIV_ONE     = 16'h0001;
  localparam logic [3:0]  SUCK_OVERSAMPLE  = 4'hf;  // sixteen minus one

  // --------------------------------------------------------------------
  // carried groups
  // --------------------------------------------------------------------
  typedef struct packed {
    logic sys_a;
    logic sys_b;
    logic usb_a;
    logic usb_b;
  } suck_straps_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } suck_bus_req_t;

  localparam logic [15:0] SUCK_REG_DIV    = 16'h0000;
  localparam logic [15:0] SUCK_REG_CTRL   = 16'h0004;
  localparam logic [15:0] SUCK_REG_STATUS = 16'h0008;
  localparam int          SUCK_CTRL_SRC   = 0;

endpackage : suck_pkg

// ---- tb/suck_asserts.sv ----
// Purpose: port checks for suck_top
// Assumes: straps steady while reset held
// Notes:   bound to every suck_top
`timescale 1ns/1ns
module suck_asserts #(
  parameter int NUM_UART = 2
) (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  // observed ports
  input wire suck_pkg::suck_straps_t  straps,
  input wire logic                    sys_osc_in,
  input wire suck_pkg::suck_bus_req_t bus,
  input wire logic [15:0]             rdata,
  input wire logic                    system_clock_output,
  input wire logic                    usb_clk48_en,
  input wire logic                    usb_bit_en,
  input wire logic [NUM_UART-1:0]     baud_en,
  input wire logic [NUM_UART-1:0]     baud16_en,
  input wire suck_pkg::suck_sys_mode_t sys_mode,
  input wire suck_pkg::suck_usb_mode_t usb_mode
);
  import suck_pkg::*;
  suck_straps_t lat_reg;
  logic [3:0]   n48_reg;
  logic [4:0]   n16_reg;
  logic         a48_reg;
  logic         a16_reg;
  // ----------------------------------------------------------------
  // pulse counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lat_reg <= straps;
      n48_reg <= 4'h0;
      n16_reg <= 5'h00;
      a48_reg <= 1'b0;
      a16_reg <= 1'b0;
    end else begin
      n48_reg <= usb_bit_en ? 4'h0 : n48_reg + {3'h0, usb_clk48_en};
      n16_reg <= baud_en[0] ? 5'h00 : n16_reg + {4'h0, baud16_en[0]};
      a48_reg <= a48_reg | usb_bit_en;
      a16_reg <= a16_reg | baud_en[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_sys_strap;
    $fell(sys_rst) |-> ##2 sys_mode == {lat_reg.sys_b, lat_reg.sys_a};
  endproperty
  a_sys_strap: assert property (p_sys_strap)
    else $error("sys mode not from straps");
  property p_usb_strap;
    $fell(sys_rst) |-> ##2 usb_mode == {lat_reg.usb_b, lat_reg.usb_a};
  endproperty
  a_usb_strap: assert property (p_usb_strap)
    else $error("usb mode not from straps");
  property p_hold;
    !$past(sys_rst) && !$past(sys_rst, 2) |->
      $stable(sys_mode) && $stable(usb_mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode moved outside reset");
  property p_stat;
    $past(bus.rd) && $past(bus.addr) == SUCK_REG_STATUS |->
      rdata == {12'h000, usb_mode, sys_mode};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read wrong");
  property p_bypass;
    sys_mode == SUCK_SYS_BYPASS && $rose(sys_osc_in) |->
      ##[1:5] system_clock_output;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass tick missing");
  property p_quiet;
    (sys_mode == SUCK_SYS_BYPASS && $stable(sys_osc_in)) [*8] |->
      !system_clock_output;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("tick with stopped input");
  property p_usb4;
    a48_reg && usb_bit_en |-> n48_reg + {3'h0, usb_clk48_en} == 4'h4;
  endproperty
  a_usb4: assert property (p_usb4)
    else $error("bit rate not 48/4");
  property p_baud16;
    a16_reg && baud_en[0] |-> n16_reg + {4'h0, baud16_en[0]} == 5'h10;
  endproperty
  a_baud16: assert property (p_baud16)
    else $error("baud not every 16th");
endmodule : suck_asserts

bind suck_top suck_asserts #(.NUM_UART(NUM_UART)) i_chk (
  .mclk(mclk), .sys_rst(sys_rst), .straps(straps),
  .sys_osc_in(sys_osc_in), .bus(bus), .rdata(rdata),
  .system_clock_output(system_clock_output),
  .usb_clk48_en(usb_clk48_en), .usb_bit_en(usb_bit_en),
  .baud_en(baud_en), .baud16_en(baud16_en),
  .sys_mode(sys_mode), .usb_mode(usb_mode));

// ---- tb/suck_ref_model.sv ----
// Purpose: reference sources beside suck_top
// Assumes: one 12-cycle phase on mclk
// Notes:   halt freezes the sources
`timescale 1ns/1ns
module suck_ref_model (
  // clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic halt,
  // sources
  output logic     sys_osc_in,
  output logic     usb_osc_in,
  output logic     usb_pll_clk48_en,
  output logic     ext_uart_clock_pin
);
  logic [3:0] ph_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst)
      ph_reg <= 4'h0;
    else if (!halt)
      ph_reg <= (ph_reg == 4'hb) ? 4'h0 : ph_reg + 4'h1;
  end
  assign sys_osc_in = ph_reg < 4'h6;
  assign usb_osc_in = 1'b0;
  assign usb_pll_clk48_en = !halt && (ph_reg % 4'h3 == 4'h0);
  assign ext_uart_clock_pin = ph_reg[1];
endmodule : suck_ref_model

// ---- tb/system_usb_clock_generation_test.sv ----
// Purpose: self-checking bench for suck_top
// Assumes: 50 MHz mclk, sync reset
// Notes:   counts use a 12-cycle reference
`timescale 1ns/1ns
module system_usb_clock_generation_test;
  import suck_pkg::*;
  logic           mclk, sys_rst, halt, sosc, uosc, c48, upin;
  logic           sclk, osc_o, usb_o, u48, ubit;
  suck_straps_t   straps;
  suck_bus_req_t  bus;
  logic [15:0]    rdata;
  logic [1:0]     ben, b16;
  suck_sys_mode_t sys_mode;
  suck_usb_mode_t usb_mode;
  int             err_count, comparisons;
  wire logic [4:0] mon = {ben[1], b16[0], b16[1], ubit, sclk};
  suck_ref_model i_ref (.mclk(mclk), .sys_rst(sys_rst), .halt(halt),
    .sys_osc_in(sosc), .usb_osc_in(uosc), .usb_pll_clk48_en(c48),
    .ext_uart_clock_pin(upin));
  suck_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .straps(straps),
    .sys_osc_in(sosc), .usb_osc_in(uosc), .usb_pll_clk48_en(c48),
    .ext_uart_clock_pin(upin), .bus(bus), .rdata(rdata),
    .system_clock_output(sclk), .sys_osc_out(osc_o),
    .usb_osc_out(usb_o), .usb_clk48_en(u48), .usb_bit_en(ubit),
    .baud_en(ben), .baud16_en(b16), .sys_mode(sys_mode),
    .usb_mode(usb_mode));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic boot(input logic [3:0] s);
    @(posedge mclk);
    straps <= s;
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : boot
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic cnt(input int w, input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(negedge mclk);
      c = c + {15'h0000, mon[w]};
    end
  endtask : cnt
  task automatic t_straps;
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      boot(i[3:0]);
      straps <= ~straps;
      repeat (4) @(posedge mclk);
      chk({14'h0, sys_mode}, {14'h0, i[2], i[3]});
      chk({14'h0, usb_mode}, {14'h0, i[0], i[1]});
      rd(SUCK_REG_STATUS, d);
      chk(d, {12'h000, i[0], i[1], i[2], i[3]});
    end
    rd(16'h0002, d);
    chk(d, 16'h0000);
  endtask : t_straps
  task automatic t_sys;
    logic [15:0] c, p;
    p = 16'h0000;
    for (int m = 1; m < 4; m++) begin
      boot({m[0], m[1], 2'b11});
      cnt(0, 240, c);
      chk({15'h0000, c > p}, 16'h0001);
      p = c;
    end
    boot(4'h3);
    cnt(0, 240, c);
    chk(c, 16'h0014);
    @(posedge mclk);
    halt <= 1'b1;
    repeat (8) @(posedge mclk);
    cnt(0, 60, c);
    chk(c, 16'h0000);
    chk({15'h0000, osc_o}, {15'h0000, ~sosc});
    chk({15'h0000, usb_o}, 16'h0000);
    @(posedge mclk);
    halt <= 1'b0;
    repeat (8) @(posedge mclk);
    cnt(0, 240, c);
    chk(c, 16'h0014);
  endtask : t_sys
  task automatic t_usb;
    logic [15:0] c;
    for (int u = 1; u < 3; u++) begin
      boot({2'b01, u[0], u[1]});
      cnt(1, 240, c);
      chk(c, 16'h0014);
    end
  endtask : t_usb
  task automatic t_baud;
    logic [15:0] c;
    boot(4'hb);
    wr(SUCK_REG_CTRL, 16'h0002);
    wr(16'h0010, 16'h0002);
    repeat (8) @(posedge mclk);
    cnt(2, 160, c);
    chk(c, 16'h0014);
    wr(SUCK_REG_CTRL, 16'h0003);
    wr(SUCK_REG_DIV, 16'h0004);
    repeat (8) @(posedge mclk);
    cnt(2, 160, c);
    chk(c, 16'h0014);
    cnt(3, 160, c);
    chk(c, 16'h000a);
    cnt(4, 1280, c);
    chk(c, 16'h000a);
  endtask : t_baud
  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    halt = 1'b0;
    straps = '0;
    bus = '0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk);
    t_straps;
    t_sys;
    t_usb;
    t_baud;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    tally_and_finish;
  end
endmodule : system_usb_clock_generation_test
